// >>> src/rx_elastic_buffer_map.svh
// Constants of the receive elastic buffer: offsets, fields, resets, counts
`ifndef RX_ELASTIC_BUFFER_MAP_SVH
`define RX_ELASTIC_BUFFER_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RXEB_CFG_OFFSET     4'h0
`define RXEB_STATUS_OFFSET  4'h4
`define RXEB_POINTER_OFFSET 4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RXEB_SIZE_LSB       0
`define RXEB_OFFSET_LSB     8
`define RXEB_POS_SLIP_BIT   0
`define RXEB_NEG_SLIP_BIT   1

// ----------------------------------------------------------------
// Reset values and mode codes
// ----------------------------------------------------------------
`define RXEB_SIZE_RESET     2'h0
`define RXEB_OFFSET_RESET   9'h000
`define RXEB_SIZE_TWO       2'h0
`define RXEB_SIZE_ONE       2'h1
`define RXEB_SIZE_SHORT     2'h2
`define RXEB_SIZE_BYPASS    2'h3

// ----------------------------------------------------------------
// Buffer sizes in bits and slip window
// ----------------------------------------------------------------
`define RXEB_BITS_TWO       10'd512
`define RXEB_BITS_ONE       10'd256
`define RXEB_BITS_SHORT     10'd96
`define RXEB_SLIP_LIMIT     10'd8
`define RXEB_FRAME_BITS     9'd256

`endif

// >>> src/rx_elastic_buffer_pkg.sv
// Types shared by the receive elastic buffer files
package rx_elastic_buffer_pkg;

    typedef enum logic [1:0] {
        size_two_frames,
        size_one_frame,
        size_short,
        size_bypass
    } buffer_size_t;

    typedef struct packed {
        logic [8:0] rx_timeslot_offset;
        logic [1:0] rx_buffer_size_sel;
    } system_interface_cfg1_t;

    typedef struct packed {
        logic       valid;
        logic       frame_start;
        logic       data;
    } line_bit_t;

endpackage : rx_elastic_buffer_pkg

// >>> src/link_edge_sampler.sv
// Two-stage synchroniser and edge finder for the pins of the route side
`timescale 1ns/100ps
`default_nettype none

module link_edge_sampler
    import rx_elastic_buffer_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic clk_en,
    input  wire logic route_clock,
    input  wire logic route_data,
    input  wire logic route_frame_start,
    output line_bit_t line_bit
);

    logic [2:0] stage1;
    logic [2:0] stage2;
    logic       last_clock;

    // ----------------------------------------------------------------
    // Synchronise, then take data on the rising route clock edge
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1     <= 3'h0;
            stage2     <= 3'h0;
            last_clock <= 1'b0;
            line_bit   <= '0;
        end else if (clk_en) begin
            stage1     <= {route_clock, route_frame_start, route_data};
            stage2     <= stage1;
            last_clock <= stage2[2];
            line_bit.valid       <= stage2[2] & ~last_clock;
            line_bit.frame_start <= stage2[1];
            line_bit.data        <= stage2[0];
        end
    end

endmodule : link_edge_sampler

`default_nettype wire

// >>> src/axi_lite_regs.sv
// AXI4-Lite slave holding configuration, slip status and pointer view
`timescale 1ns/100ps
`default_nettype none
`include "rx_elastic_buffer_map.svh"

module axi_lite_regs
    import rx_elastic_buffer_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   clk_en,
    input  wire logic [3:0]             awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [3:0]             araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    input  wire logic                   pos_slip_event,
    input  wire logic                   neg_slip_event,
    input  wire logic [8:0]             write_ptr,
    input  wire logic [8:0]             read_ptr,
    output system_interface_cfg1_t      cfg,
    output logic                        positive_slip_flag,
    output logic                        negative_slip_flag
);

    logic       aw_held;
    logic       w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       do_write;

    assign awready  = !aw_held && !bvalid;
    assign wready   = !w_held && !bvalid;
    assign arready  = !rvalid;
    assign do_write = aw_held && w_held && !bvalid;

    // ----------------------------------------------------------------
    // Write channels, taken in either order
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= 2'h0;
        end else if (clk_en) begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (aw_addr == `RXEB_CFG_OFFSET || aw_addr == `RXEB_STATUS_OFFSET)
                           ? 2'h0 : 2'h2;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Receive size and offset are private to this channel, independent of transmit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg.rx_buffer_size_sel <= `RXEB_SIZE_RESET;
            cfg.rx_timeslot_offset <= `RXEB_OFFSET_RESET;
        end else if (clk_en && do_write && aw_addr == `RXEB_CFG_OFFSET) begin
            if (w_strb[0]) begin
                cfg.rx_buffer_size_sel <= w_data[`RXEB_SIZE_LSB +: 2];
            end
            if (w_strb[1]) begin
                cfg.rx_timeslot_offset[7:0] <= w_data[`RXEB_OFFSET_LSB +: 8];
            end
            if (w_strb[2]) begin
                cfg.rx_timeslot_offset[8] <= w_data[16];
            end
        end
    end

    // Sticky slip flags, write one to clear; a new slip wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            positive_slip_flag <= 1'b0;
            negative_slip_flag <= 1'b0;
        end else if (clk_en) begin
            if (pos_slip_event) begin
                positive_slip_flag <= 1'b1;
            end else if (do_write && aw_addr == `RXEB_STATUS_OFFSET && w_strb[0]
                         && w_data[`RXEB_POS_SLIP_BIT]) begin
                positive_slip_flag <= 1'b0;
            end
            if (neg_slip_event) begin
                negative_slip_flag <= 1'b1;
            end else if (do_write && aw_addr == `RXEB_STATUS_OFFSET && w_strb[0]
                         && w_data[`RXEB_NEG_SLIP_BIT]) begin
                negative_slip_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= 2'h0;
        end else if (clk_en) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp  <= 2'h0;
                case (araddr)
                    `RXEB_CFG_OFFSET: begin
                        rdata <= {15'h0, cfg.rx_timeslot_offset, 6'h0, cfg.rx_buffer_size_sel};
                    end
                    `RXEB_STATUS_OFFSET: begin
                        rdata <= {30'h0, negative_slip_flag, positive_slip_flag};
                    end
                    `RXEB_POINTER_OFFSET: begin
                        rdata <= {7'h0, read_ptr, 7'h0, write_ptr};
                    end
                    default: begin
                        rdata <= 32'h0;
                        rresp <= 2'h2;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule : axi_lite_regs

`default_nettype wire

// >>> src/rx_elastic_buffer.sv
// Receive elastic buffer of one E1 channel, route side to system highway
// Functional notes
// - Circular storage, 64 bytes, two frames max
// - Size 00: 512 bits, delay 256
// - Size 01: 256 bits, delay 128
// - Size 10: 96 bits, delay 48
// - Size 11: buffer bypassed
// - Receive size independent of transmit size
// - Wander absorbed: 190, 100, 38 UI
// - Line bits packed into bytes, written circularly
// - System clock reads, aligned by sync plus offset; here sync plus offset only loads bit_count, which read_ptr does not use
// - Bypass: no offset, route clock drives output
// - Bypass disables the time-slot assigner
// - Bypass ignores the receive sync input
// - Slip when read pointer nears write pointer
// - Negative slip skips, positive repeats half buffer
// - Slips in all sizes except bypass
// - After slip, read sits half buffer away
// - Slip direction sets its own status flag
// - Sync plus offset marks system frame start
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "rx_elastic_buffer_map.svh"

module rx_elastic_buffer
    import rx_elastic_buffer_pkg::*;
#(
    parameter int DEPTH = 64
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic        route_clock,
    input  wire logic        route_data,
    input  wire logic        route_frame_start,
    input  wire logic        rx_system_clock,
    input  wire logic        rx_jitter_oscillator,
    input  wire logic        use_jitter_clock,
    input  wire logic        rx_frame_sync_pulse,
    output logic             rx_system_data_out,
    output logic             timeslot_assigner_en,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             positive_slip_flag,
    output logic             negative_slip_flag
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [9:0] size_bits(input logic [1:0] sel);
        case (sel)
            `RXEB_SIZE_TWO:   size_bits = `RXEB_BITS_TWO;
            `RXEB_SIZE_ONE:   size_bits = `RXEB_BITS_ONE;
            `RXEB_SIZE_SHORT: size_bits = `RXEB_BITS_SHORT;
            default:          size_bits = `RXEB_BITS_TWO;
        endcase
    endfunction : size_bits

    function automatic logic [8:0] wrap_add(input logic [9:0] a, input logic [9:0] b,
                                            input logic [9:0] lim);
        logic [10:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= {1'b0, lim}) begin
            s = s - {1'b0, lim};
        end
        // Clear to zero when a smaller size left the operand far outside
        if (s >= {1'b0, lim}) begin
            s = 11'h000;
        end
        wrap_add = s[8:0];
    endfunction : wrap_add

    system_interface_cfg1_t cfg;
    line_bit_t  line_bit;
    logic [7:0] mem [DEPTH];
    logic [8:0] write_ptr;
    logic [8:0] read_ptr;
    logic [7:0] shift_in;
    logic [9:0] limit;
    logic       bypass;
    logic       pos_slip_event;
    logic       neg_slip_event;
    logic [2:0] sys_sync1;
    logic [2:0] sys_sync2;
    logic       sys_last;
    logic       sys_edge;
    logic       sync_last;
    logic       frame_begin;
    logic [8:0] distance;
    logic [8:0] bit_count;

    assign limit  = size_bits(cfg.rx_buffer_size_sel);
    assign bypass = cfg.rx_buffer_size_sel == `RXEB_SIZE_BYPASS;
    assign timeslot_assigner_en = !bypass;

    axi_lite_regs u_regs (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .clk_en             (clk_en),
        .awaddr             (awaddr),
        .awvalid            (awvalid),
        .awready            (awready),
        .wdata              (wdata),
        .wstrb              (wstrb),
        .wvalid             (wvalid),
        .wready             (wready),
        .bresp              (bresp),
        .bvalid             (bvalid),
        .bready             (bready),
        .araddr             (araddr),
        .arvalid            (arvalid),
        .arready            (arready),
        .rdata              (rdata),
        .rresp              (rresp),
        .rvalid             (rvalid),
        .rready             (rready),
        .pos_slip_event     (pos_slip_event),
        .neg_slip_event     (neg_slip_event),
        .write_ptr          (write_ptr),
        .read_ptr           (read_ptr),
        .cfg                (cfg),
        .positive_slip_flag (positive_slip_flag),
        .negative_slip_flag (negative_slip_flag)
    );

    link_edge_sampler u_line (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .clk_en            (clk_en),
        .route_clock       (route_clock),
        .route_data        (route_data),
        .route_frame_start (route_frame_start),
        .line_bit          (line_bit)
    );

    // ----------------------------------------------------------------
    // Write side: serial to parallel, circular byte writes
    // ----------------------------------------------------------------
    // Both pointers live in aclk after sampling, so comparison is stable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            write_ptr <= 9'h000;
            shift_in  <= 8'h00;
        end else if (clk_en) begin
            if (line_bit.valid) begin
                shift_in <= {shift_in[6:0], line_bit.data};
                // Short buffer is no whole frame, so it is never frame aligned
                if (line_bit.frame_start && limit[7:0] == 8'h00) begin
                    write_ptr <= {write_ptr[8] & limit[9], 8'h01};
                end else begin
                    write_ptr <= wrap_add({1'b0, write_ptr}, 10'd1, limit);
                end
            end else if ({1'b0, write_ptr} >= limit) begin
                // A smaller size left the pointer outside; fold it back in
                write_ptr <= wrap_add({1'b0, write_ptr}, 10'd0, limit);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (clk_en && line_bit.valid && write_ptr[2:0] == 3'h7) begin
            mem[write_ptr[8:3]] <= {shift_in[6:0], line_bit.data};
        end
    end

    // ----------------------------------------------------------------
    // Read side clock and sync sampling
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_sync1 <= 3'h0;
            sys_sync2 <= 3'h0;
            sys_last  <= 1'b0;
            sync_last <= 1'b0;
        end else if (clk_en) begin
            sys_sync1 <= {rx_system_clock, rx_jitter_oscillator, rx_frame_sync_pulse};
            sys_sync2 <= sys_sync1;
            sys_last  <= use_jitter_clock ? sys_sync2[1] : sys_sync2[2];
            if (sys_edge) begin
                sync_last <= sys_sync2[0];
            end
        end
    end

    assign sys_edge    = (use_jitter_clock ? sys_sync2[1] : sys_sync2[2]) & ~sys_last;
    // Sync ignored in bypass; offset then has no meaning either
    assign frame_begin = !bypass && sys_edge && sys_sync2[0] && !sync_last;

    // ----------------------------------------------------------------
    // Read pointer, frame alignment and slips
    // ----------------------------------------------------------------
    assign distance = wrap_add({1'b0, write_ptr}, limit - {1'b0, read_ptr}, limit);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_ptr       <= 9'h000;
            bit_count      <= 9'h000;
            pos_slip_event <= 1'b0;
            neg_slip_event <= 1'b0;
        end else if (clk_en) begin
            pos_slip_event <= 1'b0;
            neg_slip_event <= 1'b0;
            if (!bypass && sys_edge) begin
                if (frame_begin) begin
                    bit_count <= cfg.rx_timeslot_offset;
                end else begin
                    bit_count <= bit_count + 9'h001;
                end
                // Window near coincidence; the side decides the slip direction
                if ({1'b0, distance} < `RXEB_SLIP_LIMIT) begin
                    pos_slip_event <= 1'b1;
                    read_ptr <= wrap_add({1'b0, write_ptr}, limit - (limit >> 1), limit);
                end else if ({1'b0, distance} > limit - `RXEB_SLIP_LIMIT) begin
                    neg_slip_event <= 1'b1;
                    read_ptr <= wrap_add({1'b0, write_ptr}, limit - (limit >> 1), limit);
                end else begin
                    read_ptr <= wrap_add({1'b0, read_ptr}, 10'd1, limit);
                end
            end else if ({1'b0, read_ptr} >= limit) begin
                read_ptr <= wrap_add({1'b0, read_ptr}, 10'd0, limit);
            end
        end
    end

    // Output bit; bypass sends the line bit on the route clock edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_system_data_out <= 1'b1;
        end else if (clk_en) begin
            if (bypass) begin
                if (line_bit.valid) begin
                    rx_system_data_out <= line_bit.data;
                end
            end else if (sys_edge) begin
                rx_system_data_out <= mem[read_ptr[8:3]][3'h7 - read_ptr[2:0]];
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    no_bypass_slip_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bypass |=> !pos_slip_event && !neg_slip_event)
        else $error("slip in bypass");
    slip_flag_pos_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && pos_slip_event |=> positive_slip_flag)
        else $error("positive slip flag not set");
    slip_flag_neg_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && neg_slip_event |=> negative_slip_flag)
        else $error("negative slip flag not set");
    slip_recenter_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pos_slip_event || neg_slip_event) && $stable(write_ptr)
        |-> {1'b0, distance} == (limit >> 1))
        else $error("read pointer not centred after slip");
    ptr_in_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !$stable(limit) || bypass || ({1'b0, write_ptr} < limit && {1'b0, read_ptr} < limit))
        else $error("pointer beyond buffer size");
    frame_align_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && line_bit.valid && line_bit.frame_start && limit[7:0] == 8'h00
        |=> write_ptr[7:0] == 8'h01)
        else $error("write pointer not aligned to frame");
    offset_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && frame_begin |=> bit_count == $past(cfg.rx_timeslot_offset))
        else $error("offset not loaded at sync");
    bypass_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && bypass && line_bit.valid |=> rx_system_data_out == $past(line_bit.data))
        else $error("bypass data mismatch");
    assigner_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bypass |-> !timeslot_assigner_en)
        else $error("assigner active in bypass");

    sclk_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && bypass && !line_bit.valid |=> $stable(rx_system_data_out))
        else $error("bypass output moved without a route edge");
    no_early_slip_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && sys_edge && {1'b0, distance} >= `RXEB_SLIP_LIMIT
        && {1'b0, distance} <= limit - `RXEB_SLIP_LIMIT |=> !pos_slip_event && !neg_slip_event)
        else $error("slip outside the slip window");

    pos_slip_c: cover property (@(posedge aclk) pos_slip_event);
    neg_slip_c: cover property (@(posedge aclk) neg_slip_event);
    bypass_c:   cover property (@(posedge aclk) bypass && line_bit.valid);
    frame_c:    cover property (@(posedge aclk) frame_begin);
    jitter_c:   cover property (@(posedge aclk) use_jitter_clock && sys_edge);

endmodule : rx_elastic_buffer

`default_nettype wire

// >>> dv/highway_model.sv
// Backplane model that makes the system clock and frame sync
`timescale 1ns/100ps
`default_nettype none
module highway_model (
    input  var int   half_ns,
    input  wire logic run,
    output logic     sclk,
    output logic     sync
);
    int n = 0;
    // Clock stands still while stopped, as a gated backplane clock would
    initial begin
        sclk = 1'b0;
        forever begin
            #(half_ns);
            if (run) sclk = ~sclk;
        end
    end
    // One pulse per 256-bit frame marks the frame start
    initial sync = 1'b0;
    always @(negedge sclk) begin
        n <= (n + 1) % 256;
        sync <= (n == 255);
    end
endmodule : highway_model
`default_nettype wire

// >>> dv/rx_elastic_buffer_tb.sv
// Testbench of the receive elastic buffer
`timescale 1ns/100ps
`default_nettype none
module rx_elastic_buffer_tb;
    logic aclk = 0, aresetn = 0, route_clock = 0, route_data = 0, route_frame_start = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, run = 0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, sclk, sync, dout, tsa_en, pflag, nflag;
    logic lastbit = 0, jsel = 0;
    logic [7:0] bcnt = 8'h00;
    int half = 200, comparisons = 0, n_fail = 0;
    rx_elastic_buffer u_rx_elastic_buffer (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .route_clock(route_clock), .route_data(route_data), .route_frame_start(route_frame_start),
        .rx_system_clock(sclk & ~jsel), .rx_jitter_oscillator(sclk & jsel),
        .use_jitter_clock(jsel),
        .rx_frame_sync_pulse(sync), .rx_system_data_out(dout), .timeslot_assigner_en(tsa_en),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .positive_slip_flag(pflag), .negative_slip_flag(nflag));
    highway_model u_highway_model (.half_ns(half), .run(run), .sclk(sclk), .sync(sync));
    initial forever #50 aclk = ~aclk;
    // Odd start offset keeps every route clock edge 13 ns after an aclk edge
    initial begin
        #13;
        forever #400 route_clock = ~route_clock;
    end
    always @(negedge route_clock) begin
        bcnt <= bcnt + 8'h01;
        route_data <= bcnt[0] ^ bcnt[2];
        route_frame_start <= (bcnt == 8'hff);
    end
    always @(posedge route_clock) lastbit <= route_data;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] v);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        r = bresp;
        bready <= 0;
        @(posedge aclk);
    endtask : wr
    task rd(input logic [3:0] a);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 0;
        @(posedge aclk);
    endtask : rd
    task give_verdict;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    task t_regs;
        rd(4'h0); chk(d, 32'h0);
        rd(4'h4); chk(d, 32'h0);
        rd(4'h8); chk(d & 32'hfe00fe00, 32'h0);
        rd(4'hc); chk(d, 32'h0); chk(r, 2'b10);
        wr(4'h8, 32'h1); chk(r, 2'b10);
        chk(tsa_en, 1'b1);
        $display("test regs done");
    endtask : t_regs
    // Bypass: output is the line bit taken at the last route edge
    task t_bypass;
        wr(4'h0, 32'h3); chk(tsa_en, 1'b0);
        repeat (4) begin
            @(posedge route_clock);
            repeat (7) @(posedge aclk);
            chk(dout, lastbit);
        end
        wr(4'h0, 32'h0); chk(tsa_en, 1'b1);
        $display("test bypass done");
    endtask : t_bypass
    // A fast reader must repeat, a slow one must skip
    task t_slip(input int h, input logic [31:0] c, input logic [31:0] exp);
        int i;
        half = h;
        jsel <= (h == 800);
        wr(4'h0, c); rd(4'h0); chk(d, c);
        run <= 1;
        repeat (200) @(posedge aclk);
        wr(4'h4, 32'h3);
        for (i = 0; i < 3000 && !(pflag | nflag); i++) @(posedge aclk);
        run <= 0;
        repeat (20) @(posedge aclk);
        rd(4'h4); chk(d, exp); chk({nflag, pflag}, exp);
        wr(4'h4, 32'h3); rd(4'h4); chk(d, 32'h0);
        $display("test slip done");
    endtask : t_slip
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_regs;
        t_bypass;
        t_slip(200, 32'h4001, 32'h1);
        t_slip(800, 32'h2, 32'h2);
        give_verdict;
    end
    initial begin
        repeat (40000) @(posedge aclk);
        n_fail++;
        give_verdict;
    end
endmodule : rx_elastic_buffer_tb
`default_nettype wire
